// ==== rtl/mda_echo_mem.sv ====
/*
  Echo buffer memory: word-addressed, registered read data.
  Assumes writes and reads come from one clock domain.
*/
`timescale 1ns/1ps
module mda_echo_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // mda_echo_mem

// ==== rtl/mda_pkg.sv ====
/*
  Package for the microcode download and activation command block:
  mode codes, sense codes, field positions, power condition codes and carriers.
  Assumes a single 200 MHz clock domain and a host-side CDB decoder.
*/
package mda_pkg;

  localparam logic [4:0] MODE_SEG_SAVE_ACT = 5'h07;
  localparam logic [4:0] MODE_ECHO_WRITE = 5'h0a;
  localparam logic [4:0] MODE_DEFER_SELECT = 5'h0d;
  localparam logic [4:0] MODE_DEFER_PLAIN = 5'h0e;
  localparam logic [4:0] MODE_ACTIVATE = 5'h0f;
  localparam logic [4:0] MODE_EXPANDER = 5'h1a;

  localparam int ACT_PO_BIT = 7;
  localparam int ACT_HR_BIT = 6;
  localparam int ACT_VSE_BIT = 5;

  localparam int SEG_ALIGN_BITS = 12;
  localparam int ECHO_ALIGN_BITS = 2;
  localparam logic [7:0] BUF_ID_RESTART = 8'h00;

  localparam logic [3:0] SENSE_NONE = 4'h0;
  localparam logic [3:0] SENSE_ILLEGAL_REQUEST = 4'h5;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_INVALID_FIELD_CDB = 8'h24;

  localparam logic [1:0] PWR_ACTIVE = 2'h0;
  localparam logic [1:0] PWR_SAVE = 2'h3;

  // command from the decoder, valid for one cycle with cmd_valid
  typedef struct packed {
    logic [4:0] mode;
    logic [7:0] buffer_id;
    logic [23:0] buffer_offset;
    logic [23:0] param_len;
    logic [7:0] mode_specific;
    logic last_segment;
  } mda_cmd_t;

  // completion reported for each command taken in idle, unless an activation event ends its echo transfer
  typedef struct packed {
    logic check_condition;
    logic [3:0] sense_key;
    logic [7:0] asc;
  } mda_status_t;

endpackage : mda_pkg

// ==== rtl/mda_top.sv ====
/*
  Microcode download and activation command interpreter for the later
  buffer-write modes: segmented download, echo buffer write, deferred
  download with selectable events, explicit activation, expander mode.
  Assumes a decoder hands in one CDB per CMD_VALID pulse, data-out words
  arrive on DOUT_VALID, and firmware performs the actual save/reset.
*/
`timescale 1ns/1ps

// Overview of operation
// - segment length must be 4K multiple
// - bad segment length gives illegal request
// - first segment starts image, but after a check condition only id 00h restarts it
// - buffer offset ignored in segmented mode
// - complete image handled like single-file save
// - save to media, self power-on reset
// - echo data stored, 4-byte aligned
// - echo data kept until another command
// - select-activation mode saves code as deferred
// - power on activates when bit 7 set
// - hard reset activates when bit 6 set
// - vendor event activates when bit 5 set
// - plain deferred activates on listed events
// - activate before format or start stop
// - spin up first; no return to power-save
// - start stop sets requested power condition
// - unit attention on reset/ssu/format activation
// - activate mode clears deferred, ignores fields
// - expander mode behaves as echo write
// - unsupported mode gives illegal request
module mda_top #(
  parameter int ECHO_DEPTH = 64
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  input wire mda_pkg::mda_cmd_t CMD,
  input wire logic DOUT_VALID,
  input wire logic [31:0] DOUT_DATA,
  input wire logic DOUT_LAST,
  input wire logic OTHER_CMD,
  input wire logic POWER_ON_EVENT,
  input wire logic HARD_RESET_EVENT,
  input wire logic VENDOR_EVENT,
  input wire logic SSU_CMD,
  input wire logic [1:0] SSU_POWER_COND,
  input wire logic SSU_POWER_CHANGE,
  input wire logic FORMAT_CMD,
  input wire logic SPIN_UP_DONE,
  input wire logic [1:0] POWER_STATE_IN,
  input wire logic [5:0] ECHO_RADDR,
  output logic [31:0] ECHO_RDATA,
  output logic ECHO_VALID,
  output logic STATUS_VALID,
  output mda_pkg::mda_status_t STATUS,
  output logic SAVE_REQ,
  output logic SELF_POR_REQ,
  output logic ACTIVATE_PULSE,
  output logic UNIT_ATTENTION,
  output logic SPIN_UP_REQ,
  output logic POWER_SET_VALID,
  output logic [1:0] POWER_SET,
  output logic DEFERRED_PENDING,
  output logic SEG_IN_PROGRESS,
  output logic FORMAT_SSU_GO
);

  localparam int AW = $clog2(ECHO_DEPTH);

  typedef enum logic [1:0] {ACT_NONE, ACT_HARD, ACT_SSU, ACT_FMT} mda_src_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ECHO_DATA, ST_SPIN} mda_phase_t;

  typedef struct packed {
    mda_phase_t phase;
    logic seg_active;
    logic restart_armed;
    logic pending;
    logic sel_mode;
    logic po_en;
    logic hr_en;
    logic vse_en;
    mda_src_t src;
    logic [1:0] ssu_cond;
    logic ssu_change;
    logic [AW-1:0] echo_ptr;
    logic echo_valid;
    logic status_valid;
    mda_pkg::mda_status_t status;
    logic save_req;
    logic self_por;
    logic activate;
    logic unit_att;
    logic spin_req;
    logic pwr_valid;
    logic [1:0] pwr;
    logic go;
  } mda_state_t;

  mda_state_t r;
  mda_state_t next_r;

  logic mem_we;
  logic [31:0] mem_rdata;

  mda_echo_mem #(.DEPTH(ECHO_DEPTH), .WIDTH(32)) u_echo (
    .clk(REF_CLK),
    .we(mem_we),
    .waddr(r.echo_ptr),
    .wdata(DOUT_DATA),
    .raddr(ECHO_RADDR[AW-1:0]),
    .rdata(mem_rdata)
  );

  // words are written only while an echo transfer is open
  assign mem_we = (r.phase == ST_ECHO_DATA) && DOUT_VALID;

  function automatic mda_pkg::mda_status_t illegal_req();
    mda_pkg::mda_status_t s;
    s.check_condition = 1'b1;
    s.sense_key = mda_pkg::SENSE_ILLEGAL_REQUEST;
    s.asc = mda_pkg::ASC_INVALID_FIELD_CDB;
    return s;
  endfunction

  function automatic mda_pkg::mda_status_t good_status();
    mda_pkg::mda_status_t s;
    s.check_condition = 1'b0;
    s.sense_key = mda_pkg::SENSE_NONE;
    s.asc = mda_pkg::ASC_NONE;
    return s;
  endfunction

  always_comb begin
    logic seg_len_ok;
    logic echo_len_ok;
    logic act_event;
    mda_src_t evt_src;
    seg_len_ok = 1'b0;
    echo_len_ok = 1'b0;
    act_event = 1'b0;
    evt_src = ACT_NONE;
    next_r = r;
    next_r.status_valid = 1'b0;
    next_r.save_req = 1'b0;
    next_r.self_por = 1'b0;
    next_r.activate = 1'b0;
    next_r.unit_att = 1'b0;
    next_r.pwr_valid = 1'b0;
    next_r.go = 1'b0;

    seg_len_ok = (CMD.param_len[mda_pkg::SEG_ALIGN_BITS-1:0] == '0);
    echo_len_ok = (CMD.param_len[mda_pkg::ECHO_ALIGN_BITS-1:0] == '0);

    // activation events outside the buffer-write command path
    if (r.pending) begin
      if (r.sel_mode) begin
        if (POWER_ON_EVENT && r.po_en) begin
          act_event = 1'b1;
          evt_src = ACT_NONE;
        end else if (HARD_RESET_EVENT && r.hr_en) begin
          act_event = 1'b1;
          evt_src = ACT_HARD;
        end else if (VENDOR_EVENT && r.vse_en) begin
          act_event = 1'b1;
          evt_src = ACT_NONE;
        end
      end else begin
        if (POWER_ON_EVENT) begin
          act_event = 1'b1;
          evt_src = ACT_NONE;
        end else if (HARD_RESET_EVENT) begin
          act_event = 1'b1;
          evt_src = ACT_HARD;
        end else if (SSU_CMD) begin
          act_event = 1'b1;
          evt_src = ACT_SSU;
        end else if (FORMAT_CMD) begin
          act_event = 1'b1;
          evt_src = ACT_FMT;
        end
      end
    end

    // in idle, format or start stop with nothing to activate proceeds at once
    if ((SSU_CMD || FORMAT_CMD) && r.phase == ST_IDLE &&
        !(act_event && (evt_src == ACT_SSU || evt_src == ACT_FMT))) begin
      next_r.go = 1'b1;
      if (SSU_CMD) begin
        next_r.pwr_valid = SSU_POWER_CHANGE;
        next_r.pwr = SSU_POWER_COND;
      end
    end

    // an intervening command releases the echo contents
    if (OTHER_CMD || CMD_VALID) begin
      next_r.echo_valid = 1'b0;
    end

    unique case (r.phase)
      ST_IDLE: begin
        if (act_event && r.phase == ST_IDLE) begin
          next_r.src = evt_src;
          next_r.ssu_cond = SSU_POWER_COND;
          next_r.ssu_change = SSU_POWER_CHANGE;
          next_r.spin_req = (POWER_STATE_IN == mda_pkg::PWR_SAVE);
          next_r.phase = ST_SPIN;
        end else if (CMD_VALID) begin
          next_r.status_valid = 1'b1;
          next_r.status = good_status();
          unique case (CMD.mode)
            mda_pkg::MODE_SEG_SAVE_ACT: begin
              // buffer offset is never looked at here
              if (!seg_len_ok) begin
                next_r.status = illegal_req();
                next_r.restart_armed = 1'b1;
              end else begin
                // only a check condition arms a restart by buffer id
                if (r.restart_armed) begin
                  next_r.seg_active = (CMD.buffer_id ==
                    mda_pkg::BUF_ID_RESTART) ? 1'b1 : r.seg_active;
                  next_r.restart_armed = 1'b0;
                end else if (!r.seg_active) begin
                  next_r.seg_active = 1'b1;
                end
                // order and total length are the initiator's duty
                if (CMD.last_segment) begin
                  next_r.seg_active = 1'b0;
                  next_r.save_req = 1'b1;
                  next_r.self_por = 1'b1;
                end
              end
            end
            mda_pkg::MODE_ECHO_WRITE, mda_pkg::MODE_EXPANDER: begin
              if (!echo_len_ok) begin
                next_r.status = illegal_req();
                next_r.restart_armed = 1'b1;
              end else begin
                next_r.status_valid = 1'b0;
                next_r.echo_ptr = '0;
                next_r.phase = ST_ECHO_DATA;
              end
            end
            mda_pkg::MODE_DEFER_SELECT: begin
              next_r.save_req = 1'b1;
              next_r.pending = 1'b1;
              next_r.sel_mode = 1'b1;
              next_r.po_en = CMD.mode_specific[mda_pkg::ACT_PO_BIT];
              next_r.hr_en = CMD.mode_specific[mda_pkg::ACT_HR_BIT];
              next_r.vse_en = CMD.mode_specific[mda_pkg::ACT_VSE_BIT];
            end
            mda_pkg::MODE_DEFER_PLAIN: begin
              next_r.save_req = 1'b1;
              next_r.pending = 1'b1;
              next_r.sel_mode = 1'b0;
            end
            mda_pkg::MODE_ACTIVATE: begin
              if (r.pending) begin
                next_r.activate = 1'b1;
                next_r.pending = 1'b0;
              end
            end
            default: begin
              next_r.status = illegal_req();
              next_r.restart_armed = 1'b1;
            end
          endcase
        end
      end
      ST_ECHO_DATA: begin
        if (act_event) begin
          // an activation event ends the transfer without status
          next_r.src = evt_src;
          next_r.ssu_cond = SSU_POWER_COND;
          next_r.ssu_change = SSU_POWER_CHANGE;
          next_r.spin_req = (POWER_STATE_IN == mda_pkg::PWR_SAVE);
          next_r.phase = ST_SPIN;
        end else if (DOUT_VALID) begin
          next_r.echo_ptr = AW'(r.echo_ptr + 1'b1);
          if (DOUT_LAST) begin
            next_r.echo_valid = 1'b1;
            next_r.status_valid = 1'b1;
            next_r.status = good_status();
            next_r.phase = ST_IDLE;
          end
        end
      end
      ST_SPIN: begin
        if (!r.spin_req || SPIN_UP_DONE) begin
          next_r.spin_req = 1'b0;
          next_r.activate = 1'b1;
          next_r.pending = 1'b0;
          next_r.unit_att = (r.src != ACT_NONE);
          next_r.phase = ST_IDLE;
          // power-on and vendor activations leave the power state alone
          if (r.src == ACT_SSU) begin
            next_r.pwr_valid = 1'b1;
            next_r.pwr = r.ssu_change ? r.ssu_cond : mda_pkg::PWR_ACTIVE;
            next_r.go = 1'b1;
          end else if (r.src == ACT_FMT) begin
            next_r.pwr_valid = 1'b1;
            next_r.pwr = mda_pkg::PWR_ACTIVE;
            next_r.go = 1'b1;
          end else if (r.src == ACT_HARD) begin
            next_r.pwr_valid = 1'b1;
            next_r.pwr = mda_pkg::PWR_ACTIVE;
          end
        end
      end
      default: begin
        next_r.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ECHO_RDATA = mem_rdata;
  assign ECHO_VALID = r.echo_valid;
  assign STATUS_VALID = r.status_valid;
  assign STATUS = r.status;
  assign SAVE_REQ = r.save_req;
  assign SELF_POR_REQ = r.self_por;
  assign ACTIVATE_PULSE = r.activate;
  assign UNIT_ATTENTION = r.unit_att;
  assign SPIN_UP_REQ = r.spin_req;
  assign POWER_SET_VALID = r.pwr_valid;
  assign POWER_SET = r.pwr;
  assign DEFERRED_PENDING = r.pending;
  assign SEG_IN_PROGRESS = r.seg_active;
  assign FORMAT_SSU_GO = r.go;

endmodule // mda_top

// ==== verification/mda_initiator.sv ====
/*
  Initiator model: issues buffer-write commands and data-out words.
  Assumes the bench calls its tasks; drives change at the falling edge.
*/
`timescale 1ns/1ps
module mda_initiator (
  input wire logic REF_CLK,
  output logic CMD_VALID,
  output mda_pkg::mda_cmd_t CMD,
  output logic DOUT_VALID,
  output logic [31:0] DOUT_DATA,
  output logic DOUT_LAST
);
  initial begin
    CMD_VALID = 1'b0;
    CMD = '0;
    DOUT_VALID = 1'b0;
    DOUT_DATA = 32'h0;
    DOUT_LAST = 1'b0;
  end
  task automatic send(mda_pkg::mda_cmd_t c);
    @(negedge REF_CLK);
    CMD_VALID = 1'b1;
    CMD = c;
    @(negedge REF_CLK);
    CMD_VALID = 1'b0;
    CMD = ~c;
  endtask
  // k whole pages per segment, sent in image order
  task automatic segment(logic [7:0] id, int k, logic last);
    mda_pkg::mda_cmd_t c;
    c = '0;
    c.mode = mda_pkg::MODE_SEG_SAVE_ACT;
    c.buffer_id = id;
    c.buffer_offset = 24'hfedcba;
    c.param_len = 24'(k) << 12;
    c.last_segment = last;
    send(c);
  endtask
  task automatic words(int n, logic [31:0] base);
    for (int i = 0; i < n; i++) begin
      @(negedge REF_CLK);
      DOUT_VALID = 1'b1;
      DOUT_DATA = base + 32'(i);
      DOUT_LAST = (i == n - 1);
    end
    @(negedge REF_CLK);
    DOUT_VALID = 1'b0;
    DOUT_LAST = 1'b0;
    DOUT_DATA = ~DOUT_DATA;
  endtask
endmodule // mda_initiator

// ==== verification/mda_props_properties.sv ====
/*
  Port checker for the download and activation block.
  Assumes it is bound to mda_top in its single clock domain.
*/
`timescale 1ns/1ps
module mda_props (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  input wire mda_pkg::mda_cmd_t CMD,
  input wire logic POWER_ON_EVENT,
  input wire logic HARD_RESET_EVENT,
  input wire logic VENDOR_EVENT,
  input wire logic SSU_CMD,
  input wire logic FORMAT_CMD,
  input wire logic SPIN_UP_DONE,
  input wire logic STATUS_VALID,
  input wire mda_pkg::mda_status_t STATUS,
  input wire logic SAVE_REQ,
  input wire logic SELF_POR_REQ,
  input wire logic ACTIVATE_PULSE,
  input wire logic UNIT_ATTENTION,
  input wire logic SPIN_UP_REQ,
  input wire logic DEFERRED_PENDING
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  logic quiet;
  logic seg;
  // activation events for deferred code win over a command in the same cycle
  assign quiet = !(POWER_ON_EVENT || HARD_RESET_EVENT || VENDOR_EVENT ||
    SSU_CMD || FORMAT_CMD);
  assign seg = CMD_VALID && quiet && CMD.mode == mda_pkg::MODE_SEG_SAVE_ACT;
  a_bad_seg_len: assert property (
    seg && CMD.param_len[11:0] != 12'h000 |=> STATUS_VALID &&
    STATUS.check_condition) else $error("bad segment length accepted");
  a_check_sense: assert property (
    STATUS_VALID && STATUS.check_condition |->
    STATUS.sense_key == mda_pkg::SENSE_ILLEGAL_REQUEST &&
    STATUS.asc == mda_pkg::ASC_INVALID_FIELD_CDB) else $error("wrong sense");
  a_image_done: assert property (
    seg && CMD.param_len[11:0] == 12'h000 && CMD.last_segment |=>
    SAVE_REQ && SELF_POR_REQ && !STATUS.check_condition)
    else $error("complete image not saved");
  a_unsup_mode: assert property (
    CMD_VALID && quiet && !(CMD.mode inside {5'h07, 5'h0a, 5'h0d, 5'h0e,
    5'h0f, 5'h1a}) |=> STATUS_VALID && STATUS.check_condition)
    else $error("unsupported mode accepted");
  a_ua_needs_act: assert property (
    UNIT_ATTENTION |-> ACTIVATE_PULSE) else $error("attention without act");
  a_act_needs_pend: assert property (
    ACTIVATE_PULSE |-> $past(DEFERRED_PENDING) && !DEFERRED_PENDING)
    else $error("activation without pending code");
  a_defer_saves: assert property (
    CMD_VALID && quiet && CMD.mode inside {5'h0d, 5'h0e} |=>
    SAVE_REQ && DEFERRED_PENDING) else $error("deferred code not held");
  a_activate_cmd: assert property (
    CMD_VALID && quiet && CMD.mode == mda_pkg::MODE_ACTIVATE &&
    DEFERRED_PENDING |=> ACTIVATE_PULSE) else $error("no activation");
  a_spin_first: assert property (
    SPIN_UP_REQ && !SPIN_UP_DONE |=> !ACTIVATE_PULSE)
    else $error("activation before spin up");
  c_refused: cover property (STATUS_VALID && STATUS.check_condition);
  c_ua: cover property (ACTIVATE_PULSE && UNIT_ATTENTION);
  c_image: cover property (SAVE_REQ && SELF_POR_REQ);
  c_spin: cover property (SPIN_UP_REQ ##1 ACTIVATE_PULSE);
endmodule // mda_props

// ==== verification/tb.sv ====
/*
  Self-checking bench: segments, echo writes, deferred activation.
  Assumes the initiator model drives the command and data-out ports.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  logic REF_CLK, RESETN, CMD_VALID, DOUT_VALID, DOUT_LAST, OTHER_CMD;
  logic POWER_ON_EVENT, HARD_RESET_EVENT, VENDOR_EVENT, SSU_CMD, FORMAT_CMD;
  logic SSU_POWER_CHANGE, SPIN_UP_DONE, ECHO_VALID, STATUS_VALID, SAVE_REQ;
  logic SELF_POR_REQ, ACTIVATE_PULSE, UNIT_ATTENTION, SPIN_UP_REQ;
  logic POWER_SET_VALID, DEFERRED_PENDING, SEG_IN_PROGRESS, FORMAT_SSU_GO;
  logic [1:0] SSU_POWER_COND, POWER_STATE_IN, POWER_SET;
  logic [5:0] ECHO_RADDR;
  logic [31:0] DOUT_DATA, ECHO_RDATA;
  mda_pkg::mda_cmd_t CMD;
  mda_pkg::mda_status_t STATUS;
  logic [4:0] ev;
  int miscompares, num_checks, cyc;
  assign {POWER_ON_EVENT, HARD_RESET_EVENT, VENDOR_EVENT, SSU_CMD,
    FORMAT_CMD} = ev;
  mda_top dut_u (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .DOUT_VALID(DOUT_VALID), .DOUT_DATA(DOUT_DATA), .DOUT_LAST(DOUT_LAST),
    .OTHER_CMD(OTHER_CMD), .POWER_ON_EVENT(POWER_ON_EVENT),
    .HARD_RESET_EVENT(HARD_RESET_EVENT), .VENDOR_EVENT(VENDOR_EVENT),
    .SSU_CMD(SSU_CMD), .SSU_POWER_COND(SSU_POWER_COND),
    .SSU_POWER_CHANGE(SSU_POWER_CHANGE), .FORMAT_CMD(FORMAT_CMD),
    .SPIN_UP_DONE(SPIN_UP_DONE), .POWER_STATE_IN(POWER_STATE_IN),
    .ECHO_RADDR(ECHO_RADDR), .ECHO_RDATA(ECHO_RDATA), .ECHO_VALID(ECHO_VALID),
    .STATUS_VALID(STATUS_VALID), .STATUS(STATUS), .SAVE_REQ(SAVE_REQ),
    .SELF_POR_REQ(SELF_POR_REQ), .ACTIVATE_PULSE(ACTIVATE_PULSE),
    .UNIT_ATTENTION(UNIT_ATTENTION), .SPIN_UP_REQ(SPIN_UP_REQ),
    .POWER_SET_VALID(POWER_SET_VALID), .POWER_SET(POWER_SET),
    .DEFERRED_PENDING(DEFERRED_PENDING), .SEG_IN_PROGRESS(SEG_IN_PROGRESS),
    .FORMAT_SSU_GO(FORMAT_SSU_GO)
  );
  mda_initiator host_u (
    .REF_CLK(REF_CLK), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .DOUT_VALID(DOUT_VALID), .DOUT_DATA(DOUT_DATA), .DOUT_LAST(DOUT_LAST)
  );
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  function automatic mda_pkg::mda_cmd_t mk(logic [4:0] m, logic [23:0] len,
    logic [7:0] ms, logic last);
    mk = '{m, 8'h33, 24'h5a5a5a, len, ms, last};
  endfunction
  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic st(logic cc);
    mda_pkg::mda_status_t x;
    x = cc ? {1'b1, mda_pkg::SENSE_ILLEGAL_REQUEST,
      mda_pkg::ASC_INVALID_FIELD_CDB} : 13'h0000;
    `CHK(STATUS_VALID, 1'b1)
    `CHK(STATUS, x)
  endtask
  task automatic t_seg();
    host_u.send(mk(mda_pkg::MODE_SEG_SAVE_ACT, 24'h001800, 8'h00, 1'b1));
    st(1'b1);
    host_u.segment(8'h00, 1, 1'b0);
    st(1'b0);
    `CHK({SEG_IN_PROGRESS, SAVE_REQ}, 2'b10)
    host_u.segment(8'h07, 2, 1'b1);
    st(1'b0);
    `CHK({SAVE_REQ, SELF_POR_REQ}, 2'b11)
  endtask
  task automatic t_echo(logic [4:0] m);
    host_u.send(mk(m, 24'h000010, 8'h00, 1'b0));
    host_u.words(4, {m, 27'h0});
    st(1'b0);
    for (int i = 0; i < 4; i++) begin
      ECHO_RADDR = 6'(i);
      repeat (2) @(negedge REF_CLK);
      `CHK(ECHO_RDATA, {m, 27'h0} + 32'(i))
    end
    `CHK(ECHO_VALID, 1'b1)
    OTHER_CMD = 1'b1;
    @(negedge REF_CLK);
    OTHER_CMD = 1'b0;
    @(negedge REF_CLK);
    `CHK(ECHO_VALID, 1'b0)
  endtask
  // e picks the event bit, 5 means an activate command
  task automatic t_act(logic plain, logic [7:0] ms, int e, logic xa,
    logic xu);
    int na, nu, ng, np;
    logic [1:0] pw;
    na = 0;
    nu = 0;
    ng = 0;
    np = 0;
    pw = (e == 1 && SSU_POWER_CHANGE) ? SSU_POWER_COND : mda_pkg::PWR_ACTIVE;
    host_u.send(mk(plain ? 5'h0e : 5'h0d, 24'h001000, ms, 1'b1));
    `CHK(DEFERRED_PENDING, 1'b1)
    if (e == 5) host_u.send(mk(mda_pkg::MODE_ACTIVATE, 24'h0, 8'h00, 1'b0));
    else begin
      ev[e] = 1'b1;
      @(negedge REF_CLK);
      ev = 5'h00;
    end
    repeat (4) begin
      na += int'(ACTIVATE_PULSE === 1'b1);
      nu += int'(UNIT_ATTENTION === 1'b1);
      ng += int'(FORMAT_SSU_GO === 1'b1);
      np += int'(POWER_SET_VALID === 1'b1);
      if (POWER_SET_VALID === 1'b1)
        `CHK(POWER_SET, pw)
      @(negedge REF_CLK);
    end
    `CHK(na, int'(xa))
    `CHK(nu, int'(xu))
    `CHK(ng, int'(e < 2))
    `CHK(np, int'(xa && (e < 2 || e == 3)))
    `CHK(DEFERRED_PENDING, !xa)
    if (!xa) host_u.send(mk(mda_pkg::MODE_ACTIVATE, 24'h0, 8'h00, 1'b0));
  endtask
  task automatic t_spin();
    POWER_STATE_IN = mda_pkg::PWR_SAVE;
    host_u.send(mk(mda_pkg::MODE_DEFER_PLAIN, 24'h002000, 8'h00, 1'b1));
    ev = 5'h01;
    @(negedge REF_CLK);
    ev = 5'h00;
    repeat (3) @(negedge REF_CLK);
    `CHK({SPIN_UP_REQ, DEFERRED_PENDING}, 2'b11)
    SPIN_UP_DONE = 1'b1;
    for (int i = 0; i < 4 && ACTIVATE_PULSE !== 1'b1; i++)
      @(negedge REF_CLK);
    SPIN_UP_DONE = 1'b0;
    `CHK({ACTIVATE_PULSE, POWER_SET_VALID, POWER_SET}, 4'hc)
    POWER_STATE_IN = mda_pkg::PWR_ACTIVE;
  endtask
  // start stop and format with nothing deferred go ahead at once
  task automatic t_go();
    ev = 5'h02;
    @(negedge REF_CLK);
    ev = 5'h01;
    `CHK(FORMAT_SSU_GO, 1'b1)
    `CHK({POWER_SET_VALID, POWER_SET}, {1'b1, SSU_POWER_COND})
    @(negedge REF_CLK);
    ev = 5'h00;
    `CHK({FORMAT_SSU_GO, POWER_SET_VALID, UNIT_ATTENTION}, 3'h4)
  endtask
  initial begin
    RESETN = 1'b0;
    ev = 5'h00;
    OTHER_CMD = 1'b0;
    SPIN_UP_DONE = 1'b0;
    SSU_POWER_CHANGE = 1'b1;
    SSU_POWER_COND = 2'h2;
    POWER_STATE_IN = mda_pkg::PWR_ACTIVE;
    ECHO_RADDR = 6'h00;
    repeat (4) @(negedge REF_CLK);
    RESETN = 1'b1;
    `CHK({STATUS_VALID, DEFERRED_PENDING, SEG_IN_PROGRESS}, 3'h0)
    t_seg();
    t_echo(mda_pkg::MODE_ECHO_WRITE);
    t_echo(mda_pkg::MODE_EXPANDER);
    host_u.send(mk(mda_pkg::MODE_EXPANDER, 24'h000012, 8'h00, 1'b0));
    st(1'b1);
    host_u.send(mk(5'h1f, 24'h0, 8'h00, 1'b0));
    st(1'b1);
    host_u.send(mk(mda_pkg::MODE_ACTIVATE, 24'h0, 8'h00, 1'b0));
    st(1'b0);
    `CHK(ACTIVATE_PULSE, 1'b0)
    t_act(1'b0, 8'h80, 4, 1'b1, 1'b0);
    t_act(1'b0, 8'h60, 4, 1'b0, 1'b0);
    t_act(1'b0, 8'h40, 3, 1'b1, 1'b1);
    t_act(1'b0, 8'ha0, 3, 1'b0, 1'b0);
    t_act(1'b0, 8'h20, 2, 1'b1, 1'b0);
    t_act(1'b0, 8'hc0, 2, 1'b0, 1'b0);
    t_act(1'b0, 8'h00, 5, 1'b1, 1'b0);
    t_act(1'b1, 8'h00, 4, 1'b1, 1'b0);
    t_act(1'b1, 8'h00, 3, 1'b1, 1'b1);
    t_act(1'b1, 8'h00, 1, 1'b1, 1'b1);
    t_act(1'b1, 8'h00, 0, 1'b1, 1'b1);
    t_act(1'b1, 8'h00, 5, 1'b1, 1'b0);
    SSU_POWER_CHANGE = 1'b0;
    t_act(1'b1, 8'h00, 1, 1'b1, 1'b1);
    SSU_POWER_CHANGE = 1'b1;
    t_spin();
    t_go();
    report_and_stop();
  end
endmodule // tb
bind mda_top mda_props chk_u (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD(CMD),
  .POWER_ON_EVENT(POWER_ON_EVENT), .HARD_RESET_EVENT(HARD_RESET_EVENT),
  .VENDOR_EVENT(VENDOR_EVENT), .SSU_CMD(SSU_CMD), .FORMAT_CMD(FORMAT_CMD),
  .SPIN_UP_DONE(SPIN_UP_DONE), .STATUS_VALID(STATUS_VALID), .STATUS(STATUS),
  .SAVE_REQ(SAVE_REQ), .SELF_POR_REQ(SELF_POR_REQ),
  .ACTIVATE_PULSE(ACTIVATE_PULSE), .UNIT_ATTENTION(UNIT_ATTENTION),
  .SPIN_UP_REQ(SPIN_UP_REQ), .DEFERRED_PENDING(DEFERRED_PENDING)
);
